// File: accel_operating_mode_control_bench.sv
// Testbench for the operating-mode controller with a host model.
// Assumes inputs driven at falling edges and outputs settled a half cycle later.
module accel_operating_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk = 1'b0, nrst = 1'b0, supply_ok = 1'b1, ok;
  logic              active_req = 1'b0, sleep_req = 1'b0, wake_req = 1'b0, self_test = 1'b0, sample_stb = 1'b0;
  logic [1:0]        range_sel = 2'h0, system_mode_field;
  logic signed [11:0] raw = 12'h000, stim = 12'h000;
  logic              bus_req, bus_we, bus_ack, analog_en, sample_clk_en, digital_en;
  logic [7:0]        bus_wdata, cfg_q, subset_q, out_base;
  logic signed [9:0] out_x, out_y, out_z;
  logic [9:0]        pos [3] = '{10'h0C8, 10'h064, 10'h032};
  logic [9:0]        neg [3] = '{10'h338, 10'h39C, 10'h3CE};
  int                n_errors = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  aomc_host u_host (.core_clk, .bus_ack, .bus_req, .bus_we, .bus_wdata);
  aomc_mode_ctrl u_dut (.core_clk, .nrst, .supply_ok, .active_req, .sleep_req, .wake_req, .bus_req, .bus_we,
    .bus_wdata, .self_test, .range_sel, .sample_stb, .raw_x(raw), .raw_y(-raw), .raw_z(raw), .stim_x(stim),
    .stim_y(stim), .stim_z(stim), .bus_ack, .analog_en, .sample_clk_en, .digital_en, .system_mode_field,
    .cfg_q, .subset_q, .out_base, .out_x, .out_y, .out_z);
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic en3(input logic d, input logic a, input logic s, input logic [1:0] m);
    chk("digital_en", 16'(digital_en), 16'(d));
    chk("analog_en", 16'(analog_en), 16'(a));
    chk("sample_clk_en", 16'(sample_clk_en), 16'(s));
    chk("mode", 16'(system_mode_field), 16'(m));
  endtask
  task automatic sample();
    sample_stb = 1'b1;
    cyc(1);
    sample_stb = 1'b0;
    cyc(2);
  endtask
  task automatic t_standby();
    en3(1'b1, 1'b0, 1'b0, aomc_pkg::AOMC_SYS_STANDBY);
    u_host.write(8'hA5, ok);
    chk("ack", 16'(ok), 16'h0001);
    chk("cfg", 16'(cfg_q), 16'h00A5);
  endtask
  task automatic t_active();
    active_req = 1'b1;
    cyc(1);
    en3(1'b1, 1'b1, 1'b1, aomc_pkg::AOMC_SYS_WAKE);
    chk("subset", 16'(subset_q), 16'h0000);
    chk("cfg", 16'(cfg_q), 16'h00A5);
    u_host.write(8'h3C, ok);
    chk("ack", 16'(ok), 16'h0001);
  endtask
  task automatic t_scale();
    stim = 12'h040;
    raw = 12'h0C8;
    for (int i = 0; i < 3; i++) begin
      range_sel = 2'(i);
      sample();
      chk("out_x", 16'($unsigned(out_x)), 16'(pos[i]));
      chk("out_y", 16'($unsigned(out_y)), 16'(neg[i]));
    end
    range_sel = 2'h3;
    raw = 12'h300;
    sample();
    chk("out_x", 16'($unsigned(out_x)), 16'h01FF);
    chk("out_y", 16'($unsigned(out_y)), 16'h0200);
    chk("out_base", 16'(out_base), 16'h0000);
    range_sel = aomc_pkg::AOMC_FS_4G;
    raw = 12'h064;
    stim = 12'h03C;
    self_test = 1'b1;
    sample();
    chk("out_z", 16'($unsigned(out_z)), 16'h0050);
    self_test = 1'b0;
  endtask
  task automatic t_sub();
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    en3(1'b1, 1'b1, 1'b1, aomc_pkg::AOMC_SYS_SLEEP);
    wake_req = 1'b1;
    cyc(1);
    wake_req = 1'b0;
    chk("mode", 16'(system_mode_field), 16'(aomc_pkg::AOMC_SYS_WAKE));
  endtask
  task automatic t_retain();
    active_req = 1'b0;
    cyc(1);
    en3(1'b1, 1'b0, 1'b0, aomc_pkg::AOMC_SYS_STANDBY);
    chk("cfg", 16'(cfg_q), 16'h003C);
    chk("subset", 16'(subset_q), 16'h003C);
    raw = 12'h010;
    sample();
    chk("out_z", 16'($unsigned(out_z)), 16'h0050);
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    chk("mode", 16'(system_mode_field), 16'(aomc_pkg::AOMC_SYS_STANDBY));
  endtask
  task automatic t_off();
    supply_ok = 1'b0;
    cyc(1);
    en3(1'b0, 1'b0, 1'b0, 2'h0);
    u_host.write(8'h77, ok);
    chk("ack", 16'(ok), 16'h0000);
    chk("cfg", 16'(cfg_q), 16'h003C);
    supply_ok = 1'b1;
    cyc(1);
    chk("digital_en", 16'(digital_en), 16'h0001);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Generous bound: the sequence needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
  initial begin
    cyc(3);
    nrst = 1'b1;
    cyc(2);
    t_standby();
    t_active();
    t_scale();
    t_sub();
    t_retain();
    t_off();
    final_report();
  end
endmodule

// File: aomc_host.sv
// Host model: bus controller that writes configuration bytes.
// Assumes the combinational acknowledge of the mode controller on core_clk.
module aomc_host (
  input  wire logic       core_clk,
  input  wire logic       bus_ack,
  output logic            bus_req,
  output logic            bus_we,
  output logic [7:0]      bus_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_req = 1'b0;
    bus_we = 1'b0;
    bus_wdata = 8'h00;
  end
  // Config in standby, then again while active
  task automatic write(input logic [7:0] d, output logic acked);
    @(negedge core_clk);
    bus_req = 1'b1;
    bus_we = 1'b1;
    bus_wdata = d;
    @(posedge core_clk);
    acked = bus_ack;
    @(negedge core_clk);
    bus_req = 1'b0;
    bus_we = 1'b0;
    bus_wdata = ~d; // Released byte never repeats the last one
  endtask
endmodule

// File: aomc_mode_ctrl.sv
// Operating-mode controller: off, standby, active wake and sleep.
// Assumes power-good, mode requests and the host bus all on core_clk;
// the supply detector drives supply_ok low below the core threshold.
module aomc_mode_ctrl #(
  parameter int W     = aomc_pkg::AOMC_DATA_W,
  parameter int SUB_W = aomc_pkg::AOMC_SUBSET_W
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              supply_ok,
  input  wire logic              active_req,
  input  wire logic              sleep_req,
  input  wire logic              wake_req,
  input  wire logic              bus_req,
  input  wire logic              bus_we,
  input  wire logic [SUB_W-1:0]  bus_wdata,
  input  wire logic              self_test,
  input  wire logic [1:0]        range_sel,
  input  wire logic              sample_stb,
  input  wire logic signed [W+1:0] raw_x,
  input  wire logic signed [W+1:0] raw_y,
  input  wire logic signed [W+1:0] raw_z,
  input  wire logic signed [W+1:0] stim_x,
  input  wire logic signed [W+1:0] stim_y,
  input  wire logic signed [W+1:0] stim_z,
  output logic                   bus_ack,
  output logic                   analog_en,
  output logic                   sample_clk_en,
  output logic                   digital_en,
  output logic [1:0]             system_mode_field,
  output logic [SUB_W-1:0]       cfg_q,
  output logic [SUB_W-1:0]       subset_q,
  output logic [7:0]             out_base,
  output logic signed [W-1:0]    out_x,
  output logic signed [W-1:0]    out_y,
  output logic signed [W-1:0]    out_z
);
  aomc_pkg::aomc_mode_t mode_q;
  aomc_pkg::aomc_mode_t mode_d;
  logic                 is_active;
  logic                 powered;
  logic                 go_active;

  // One decode for both active sub-states keeps enables and sample gating in step
  function automatic logic act_mode(input aomc_pkg::aomc_mode_t m);
    act_mode = (m == aomc_pkg::AOMC_MODE_WAKE) || (m == aomc_pkg::AOMC_MODE_SLEEP);
  endfunction

  assign is_active = act_mode(mode_q);
  assign powered   = (mode_q != aomc_pkg::AOMC_MODE_OFF);
  assign go_active = (mode_q == aomc_pkg::AOMC_MODE_STANDBY) && (mode_d == aomc_pkg::AOMC_MODE_WAKE);

  // Active is entered in wake; sleep is only reachable from wake
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      aomc_pkg::AOMC_MODE_OFF: begin
        if (supply_ok) mode_d = aomc_pkg::AOMC_MODE_STANDBY;
      end
      aomc_pkg::AOMC_MODE_STANDBY: begin
        if (active_req) mode_d = aomc_pkg::AOMC_MODE_WAKE;
      end
      aomc_pkg::AOMC_MODE_WAKE: begin
        if (!active_req) mode_d = aomc_pkg::AOMC_MODE_STANDBY;
        else if (sleep_req) mode_d = aomc_pkg::AOMC_MODE_SLEEP;
      end
      aomc_pkg::AOMC_MODE_SLEEP: begin
        if (!active_req) mode_d = aomc_pkg::AOMC_MODE_STANDBY;
        else if (wake_req) mode_d = aomc_pkg::AOMC_MODE_WAKE;
      end
      default: mode_d = aomc_pkg::AOMC_MODE_OFF;
    endcase
    // Supply loss overrides everything
    if (!supply_ok) mode_d = aomc_pkg::AOMC_MODE_OFF;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) mode_q <= aomc_pkg::AOMC_MODE_OFF;
    else mode_q <= mode_d;
  end

  // Block enables follow the mode
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      analog_en     <= 1'b0;
      sample_clk_en <= 1'b0;
      digital_en    <= 1'b0;
    end else begin
      analog_en     <= act_mode(mode_d);
      sample_clk_en <= act_mode(mode_d);
      digital_en    <= (mode_d != aomc_pkg::AOMC_MODE_OFF);
    end
  end

  // Bus answered only while powered
  assign bus_ack = bus_req && powered;

  // Config writes are taken in any powered mode; the host writes in both
  // standby and active. Leaving active touches nothing here.
  always_ff @(posedge core_clk) begin
    if (!nrst) cfg_q <= '0;
    else if (bus_ack && bus_we) cfg_q <= bus_wdata;
  end

  // Subset resets on entry to active; a same-cycle write loses, since the
  // reset marks the start of sampling.
  always_ff @(posedge core_clk) begin
    if (!nrst) subset_q <= aomc_pkg::AOMC_SUBSET_RST;
    else if (go_active) subset_q <= aomc_pkg::AOMC_SUBSET_RST;
    else if (bus_ack && bus_we) subset_q <= bus_wdata;
  end

  // Status code readable whenever the bus answers
  always_ff @(posedge core_clk) begin
    if (!nrst) system_mode_field <= aomc_pkg::AOMC_SYS_STANDBY;
    else if (mode_d == aomc_pkg::AOMC_MODE_WAKE) system_mode_field <= aomc_pkg::AOMC_SYS_WAKE;
    else if (mode_d == aomc_pkg::AOMC_MODE_SLEEP) system_mode_field <= aomc_pkg::AOMC_SYS_SLEEP;
    else system_mode_field <= aomc_pkg::AOMC_SYS_STANDBY;
  end

  assign out_base = aomc_pkg::AOMC_OUT_BASE;

  logic stb_act;
  assign stb_act = sample_stb && is_active;

  aomc_scaler #(.W(W)) u_sx (
    .core_clk(core_clk), .nrst(nrst), .sample_stb(stb_act), .self_test(self_test),
    .range_sel(range_sel), .raw_in(raw_x), .stim_in(stim_x), .out_q(out_x)
  );
  aomc_scaler #(.W(W)) u_sy (
    .core_clk(core_clk), .nrst(nrst), .sample_stb(stb_act), .self_test(self_test),
    .range_sel(range_sel), .raw_in(raw_y), .stim_in(stim_y), .out_q(out_y)
  );
  aomc_scaler #(.W(W)) u_sz (
    .core_clk(core_clk), .nrst(nrst), .sample_stb(stb_act), .self_test(self_test),
    .range_sel(range_sel), .raw_in(raw_z), .stim_in(stim_z), .out_q(out_z)
  );

  sequence leave_standby_s;
    (mode_q == aomc_pkg::AOMC_MODE_STANDBY) ##1 (mode_q == aomc_pkg::AOMC_MODE_WAKE);
  endsequence

  standby_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_STANDBY) ##1 (mode_q == aomc_pkg::AOMC_MODE_STANDBY)
      |-> !analog_en && !sample_clk_en && digital_en)
    else $error("analog or clocks on in standby");
  standby_bus_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (bus_req && mode_q == aomc_pkg::AOMC_MODE_STANDBY) |-> bus_ack)
    else $error("standby bus request not answered");
  active_enable_a: assert property (@(posedge core_clk) disable iff (!nrst)
    leave_standby_s |-> analog_en && sample_clk_en && digital_en)
    else $error("active entered without enables");
  keep_cfg_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (is_active && mode_d == aomc_pkg::AOMC_MODE_STANDBY && !(bus_ack && bus_we)) |=> $stable(cfg_q) && $stable(subset_q))
    else $error("registers changed leaving active");
  subset_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
    leave_standby_s |-> subset_q == aomc_pkg::AOMC_SUBSET_RST)
    else $error("subset not reset entering active");
  sleep_path_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_STANDBY) |=> mode_q != aomc_pkg::AOMC_MODE_SLEEP)
    else $error("sleep entered outside active");
  off_silent_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !supply_ok |=> !bus_ack && !analog_en && !digital_en)
    else $error("device not shut down without supply");
  status_code_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_SLEEP) |-> system_mode_field == aomc_pkg::AOMC_SYS_SLEEP)
    else $error("status field disagrees with sleep");

  sequence quiet_go_active_s;
    (mode_q == aomc_pkg::AOMC_MODE_STANDBY && !(bus_ack && bus_we)) ##1 (mode_q == aomc_pkg::AOMC_MODE_WAKE);
  endsequence

  // Properties below watch only what this block drives
  // Outputs frozen outside active: no sampling clock can move them
  hold_outputs_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !is_active |=> $stable(out_x) && $stable(out_y) && $stable(out_z))
    else $error("outputs moved outside active");
  standby_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_STANDBY && bus_ack && bus_we) |=> cfg_q == $past(bus_wdata))
    else $error("standby write not taken");
  sleep_enable_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_SLEEP) |-> analog_en && sample_clk_en && digital_en)
    else $error("sleep sub-state lost its enables");
  sleep_exit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_SLEEP && !active_req && supply_ok) |=> mode_q == aomc_pkg::AOMC_MODE_STANDBY)
    else $error("sleep did not return to standby");
  other_regs_a: assert property (@(posedge core_clk) disable iff (!nrst)
    quiet_go_active_s |-> $stable(cfg_q))
    else $error("config changed entering active");
  active_bus_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (bus_req && is_active) |-> bus_ack)
    else $error("active bus request not answered");
  off_regs_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_OFF) |=> $stable(cfg_q) && $stable(subset_q))
    else $error("registers written while off");
  off_enables_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_OFF) |-> !analog_en && !sample_clk_en && !digital_en)
    else $error("blocks enabled while off");
  status_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_STANDBY || mode_q == aomc_pkg::AOMC_MODE_OFF)
      |-> system_mode_field == aomc_pkg::AOMC_SYS_STANDBY)
    else $error("status field disagrees with standby");
  status_wake_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (mode_q == aomc_pkg::AOMC_MODE_WAKE) |-> system_mode_field == aomc_pkg::AOMC_SYS_WAKE)
    else $error("status field disagrees with wake");
  // A full-width input shifted for 8 g always fits, so saturation never hides a fault
  range_8g_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (stb_act && !self_test && range_sel == aomc_pkg::AOMC_FS_8G) |=> out_x == ($past(raw_x) >>> aomc_pkg::AOMC_SHIFT_8G))
    else $error("8 g scaling wrong on x");
endmodule

// File: aomc_pkg.sv
// Package for the accelerometer operating-mode controller.
// Assumes a single 100 MHz core clock and a host write bus with no read path.
package aomc_pkg;
  typedef enum logic [1:0] {
    AOMC_MODE_OFF,
    AOMC_MODE_STANDBY,
    AOMC_MODE_WAKE,
    AOMC_MODE_SLEEP
  } aomc_mode_t;

  // Status field codes reported to the host
  localparam logic [1:0] AOMC_SYS_STANDBY = 2'h0;
  localparam logic [1:0] AOMC_SYS_WAKE    = 2'h1;
  localparam logic [1:0] AOMC_SYS_SLEEP   = 2'h2;

  // Full-scale range selection codes
  localparam logic [1:0] AOMC_FS_2G = 2'h0;
  localparam logic [1:0] AOMC_FS_4G = 2'h1;
  localparam logic [1:0] AOMC_FS_8G = 2'h2;

  // Shift applied to a 2 g scaled raw value: 256, 128, 64 counts per g
  localparam logic [1:0] AOMC_SHIFT_2G = 2'h0;
  localparam logic [1:0] AOMC_SHIFT_4G = 2'h1;
  localparam logic [1:0] AOMC_SHIFT_8G = 2'h2;

  localparam int          AOMC_DATA_W      = 10;
  localparam int          AOMC_SUBSET_W    = 8;
  localparam logic [7:0]  AOMC_OUT_BASE    = 8'h00;
  localparam logic [7:0]  AOMC_SUBSET_RST  = 8'h00;
endpackage

// File: aomc_scaler.sv
// One-axis output scaler: raw plus self-test stimulus, scaled by range.
// Assumes raw and stimulus arrive at 256 counts per g on the core clock.
module aomc_scaler #(
  parameter int W = aomc_pkg::AOMC_DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              sample_stb,
  input  wire logic              self_test,
  input  wire logic [1:0]        range_sel,
  input  wire logic signed [W+1:0] raw_in,
  input  wire logic signed [W+1:0] stim_in,
  output logic signed [W-1:0]    out_q
);
  function automatic logic [1:0] range_shift(input logic [1:0] r);
    if (r == aomc_pkg::AOMC_FS_4G) range_shift = aomc_pkg::AOMC_SHIFT_4G;
    else if (r == aomc_pkg::AOMC_FS_8G) range_shift = aomc_pkg::AOMC_SHIFT_8G;
    else range_shift = aomc_pkg::AOMC_SHIFT_2G;
  endfunction

  logic signed [W+2:0] sum_w;
  logic signed [W+2:0] scaled_w;

  // Stimulus adds to true acceleration before scaling
  assign sum_w    = self_test ? (W+3)'(raw_in + stim_in) : (W+3)'(raw_in);
  assign scaled_w = sum_w >>> range_shift(range_sel);

  // Saturate rather than wrap so a full-scale hit stays signed
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      out_q <= '0;
    end else if (sample_stb) begin
      if (scaled_w > (W+3)'((1 <<< (W-1)) - 1))
        out_q <= W'((1 <<< (W-1)) - 1);
      else if (scaled_w < -(W+3)'(1 <<< (W-1)))
        out_q <= W'(-(1 <<< (W-1)));
      else
        out_q <= W'(scaled_w);
    end
  end
endmodule
